// ### sfbl_loader.sv
// boot-time configuration loader: internal self load or external flash boot
`timescale 1ns/1ps
`default_nettype none
// Operation
// - self load on power-up, reload, reprogram request
// - oversized image loads from external flash instead
// - no flash boot in hardware-default state
// - missing preamble within timeout fails boot
// - only read opcode 03 is issued
// - flash fetch starts after reprogram released
// - serial clock pin drives nominal 2.08 MHz until the rate byte is read
// - select low, commands out, data in
// - after image, deselect and float pins
// - every flash load starts at slow rate
// - rate byte after preamble sets faster clock
// - user mode leaves loader pins floating
// - user SPI master reaches same pins
// - test port passes through to flash
module sfbl_loader (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        reload_cmd,
  input  wire logic        reprogram_request_n,
  input  wire logic        hw_default_state,
  input  wire logic        image_fits_internal,
  input  wire logic [23:0] image_byte_count,
  output logic             isl_rd,
  output logic [23:0]      isl_addr,
  input  wire logic [7:0]  isl_data,
  input  wire logic        flash_data_in,
  output logic             flash_sclk_o,
  output logic             flash_sclk_oe,
  output logic             flash_select_n_o,
  output logic             flash_select_n_oe,
  output logic             flash_command_out_o,
  output logic             flash_command_out_oe,
  input  wire logic        user_spi_en,
  input  wire logic        user_sclk,
  input  wire logic        user_mosi,
  input  wire logic        user_select_n,
  output logic             user_miso,
  input  wire logic        tap_pt_en,
  input  wire logic        tap_pt_sclk,
  input  wire logic        tap_pt_mosi,
  input  wire logic        tap_pt_select_n,
  output logic             tap_pt_miso,
  output logic [7:0]       cfg_data,
  output logic             cfg_valid,
  input  wire logic        cfg_ready,
  output logic             load_busy,
  output logic             load_done,
  output logic             boot_failed,
  output logic [7:0]       load_clock_rate_setting
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    sfbl_pkg::sfbl_state_t st;
    logic [1:0]            req_sync;
    logic [1:0]            miso_sync;
    logic [7:0]            tap_sync;
    logic                  req_prev;
    logic                  pending;
    logic                  isl_wait;
    logic                  isl_rd;
    logic [23:0]           addr;
    logic [23:0]           remain;
    logic [1:0]            cmd_idx;
    logic                  sh_busy;
    logic [7:0]            prev_byte;
    logic [7:0]            hunt_cnt;
    logic [7:0]            half;
    logic [7:0]            rate;
    logic                  sclk_o;
    logic                  sclk_oe;
    logic                  sel_o;
    logic                  sel_oe;
    logic                  mosi_o;
    logic                  mosi_oe;
    logic                  user_miso;
    logic                  tap_miso;
    logic                  busy;
    logic                  done;
    logic                  failed;
  } sfbl_top_t;

  sfbl_top_t s_q;
  sfbl_top_t s_d;

  logic       sh_start;
  logic [7:0] sh_tx;
  logic       sh_sclk;
  logic       sh_mosi;
  logic       sh_done;
  logic [7:0] sh_rx;
  logic       push_valid;
  logic [7:0] push_data;
  logic       push_ready;

  // map the rate setting to a half period, never below the sampling margin
  function automatic logic [7:0] rate_half(input logic [7:0] setting);
    logic [7:0] h;
    h = sfbl_pkg::SLOW_HALF;
    if (setting[2:0] > sfbl_pkg::RATE_MAX) begin
      h = sfbl_pkg::SLOW_HALF >> sfbl_pkg::RATE_MAX;
    end else begin
      h = sfbl_pkg::SLOW_HALF >> setting[2:0];
    end
    if (h < sfbl_pkg::MIN_HALF) begin
      h = sfbl_pkg::MIN_HALF;
    end
    return h;
  endfunction : rate_half

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d            = s_q;
    sh_start       = 1'b0;
    sh_tx          = 8'h00;
    push_valid     = 1'b0;
    push_data      = 8'h00;
    s_d.req_sync   = {s_q.req_sync[0], reprogram_request_n};
    s_d.miso_sync  = {s_q.miso_sync[0], flash_data_in};
    s_d.tap_sync   = {s_q.tap_sync[3:0], tap_pt_en, tap_pt_sclk, tap_pt_mosi, tap_pt_select_n};
    s_d.req_prev   = s_q.req_sync[1];
    s_d.isl_rd     = 1'b0;
    if (sh_done) s_d.sh_busy = 1'b0;
    case (s_q.st)
      sfbl_pkg::ST_IDLE, sfbl_pkg::ST_DONE, sfbl_pkg::ST_FAIL: begin
        if (s_q.pending && s_q.req_sync[1]) begin
          s_d.pending = 1'b0;
          s_d.busy    = 1'b1;
          s_d.done    = 1'b0;
          s_d.failed  = 1'b0;
          s_d.remain  = image_byte_count;
          s_d.half    = sfbl_pkg::SLOW_HALF;
          s_d.rate    = 8'h00;
          s_d.addr    = sfbl_pkg::IMAGE_ADDR;
          if (image_fits_internal) begin
            s_d.st = sfbl_pkg::ST_SELF;
          end else if (hw_default_state) begin
            s_d.st     = sfbl_pkg::ST_FAIL;
            s_d.busy   = 1'b0;
            s_d.failed = 1'b1;
          end else begin
            s_d.st      = sfbl_pkg::ST_CMD;
            s_d.cmd_idx = 2'h0;
            s_d.sel_o   = 1'b0;
            s_d.sel_oe  = 1'b1;
            s_d.sclk_oe = 1'b1;
            s_d.mosi_oe = 1'b1;
          end
        end
      end
      sfbl_pkg::ST_SELF: begin
        if (s_q.remain == 24'h000000) begin
          s_d.st   = sfbl_pkg::ST_DONE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end else if (!s_q.isl_wait) begin
          s_d.isl_rd   = 1'b1;
          s_d.isl_wait = 1'b1;
        end else if (!s_q.isl_rd && push_ready) begin
          push_valid   = 1'b1;
          push_data    = isl_data;
          s_d.isl_wait = 1'b0;
          s_d.addr     = s_q.addr + 24'h000001;
          s_d.remain   = s_q.remain - 24'h000001;
        end
      end
      sfbl_pkg::ST_CMD: begin
        if (!s_q.sh_busy && !sh_done) begin
          sh_start    = 1'b1;
          s_d.sh_busy = 1'b1;
          case (s_q.cmd_idx)
            2'h0:    sh_tx = sfbl_pkg::READ_OPCODE;
            2'h1:    sh_tx = s_q.addr[23:16];
            2'h2:    sh_tx = s_q.addr[15:8];
            default: sh_tx = s_q.addr[7:0];
          endcase
        end else if (sh_done) begin
          if (s_q.cmd_idx == sfbl_pkg::CMD_BYTES_M1) begin
            s_d.st       = sfbl_pkg::ST_HUNT;
            s_d.hunt_cnt = 8'h00;
            s_d.prev_byte = 8'h00;
          end else begin
            s_d.cmd_idx = s_q.cmd_idx + 2'h1;
          end
        end
      end
      sfbl_pkg::ST_HUNT, sfbl_pkg::ST_RATE: begin
        if (!s_q.sh_busy && !sh_done) begin
          sh_start    = 1'b1;
          s_d.sh_busy = 1'b1;
        end else if (sh_done) begin
          s_d.prev_byte = sh_rx;
          if (s_q.st == sfbl_pkg::ST_RATE) begin
            s_d.rate = sh_rx;
            s_d.half = rate_half(sh_rx);
            s_d.st   = sfbl_pkg::ST_DATA;
          end else if ({s_q.prev_byte, sh_rx} == sfbl_pkg::PREAMBLE) begin
            s_d.st = sfbl_pkg::ST_RATE;
          end else if (s_q.hunt_cnt == sfbl_pkg::HUNT_MAX) begin
            s_d.st = sfbl_pkg::ST_WAIT;
            s_d.failed = 1'b1;
          end else begin
            s_d.hunt_cnt = s_q.hunt_cnt + 8'h01;
          end
        end
      end
      sfbl_pkg::ST_DATA: begin
        if (s_q.remain == 24'h000000) begin
          s_d.st = sfbl_pkg::ST_WAIT;
        end else if (!s_q.sh_busy && !sh_done && push_ready) begin
          // space checked before starting, so the finished byte always fits
          sh_start    = 1'b1;
          s_d.sh_busy = 1'b1;
        end else if (sh_done) begin
          push_valid = 1'b1;
          push_data  = sh_rx;
          s_d.remain = s_q.remain - 24'h000001;
        end
      end
      sfbl_pkg::ST_WAIT: begin
        // end of read: deselect and release the pins
        s_d.sel_o   = 1'b1;
        s_d.sel_oe  = 1'b0;
        s_d.sclk_oe = 1'b0;
        s_d.mosi_oe = 1'b0;
        s_d.busy    = 1'b0;
        s_d.done    = !s_q.failed;
        s_d.st      = s_q.failed ? sfbl_pkg::ST_FAIL : sfbl_pkg::ST_DONE;
      end
      default: begin
        s_d.st = sfbl_pkg::ST_IDLE;
      end
    endcase
    // reload command, or reprogram request released; after the case so a trigger beats the start
    if (reload_cmd || (s_q.req_sync[1] && !s_q.req_prev)) s_d.pending = 1'b1;
    // pin ownership: loader while it reads, else test port or user master
    if (s_q.st == sfbl_pkg::ST_CMD || s_q.st == sfbl_pkg::ST_HUNT ||
        s_q.st == sfbl_pkg::ST_RATE || s_q.st == sfbl_pkg::ST_DATA) begin
      s_d.sclk_o = sh_sclk;
      s_d.mosi_o = sh_mosi;
    end else if (!s_d.busy && s_q.tap_sync[7]) begin
      s_d.sclk_o  = s_q.tap_sync[6];
      s_d.mosi_o  = s_q.tap_sync[5];
      s_d.sel_o   = s_q.tap_sync[4];
      s_d.sclk_oe = 1'b1;
      s_d.mosi_oe = 1'b1;
      s_d.sel_oe  = 1'b1;
    end else if (!s_d.busy && user_spi_en) begin
      s_d.sclk_o  = user_sclk;
      s_d.mosi_o  = user_mosi;
      s_d.sel_o   = user_select_n;
      s_d.sclk_oe = 1'b1;
      s_d.mosi_oe = 1'b1;
      s_d.sel_oe  = 1'b1;
    end else if (!s_d.busy) begin
      s_d.sclk_oe = 1'b0;
      s_d.mosi_oe = 1'b0;
      s_d.sel_oe  = 1'b0;
      s_d.sel_o   = 1'b1;
    end
    s_d.user_miso = s_q.miso_sync[1];
    s_d.tap_miso  = s_q.miso_sync[1];
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q          <= '0;
      s_q.st       <= sfbl_pkg::ST_IDLE;
      s_q.pending  <= 1'b1;
      s_q.req_sync <= 2'b11;
      s_q.req_prev <= 1'b1;
      s_q.half     <= sfbl_pkg::SLOW_HALF;
      s_q.sel_o    <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // submodules
  // ****************************************
  sfbl_spi_shift u_shift (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .start     (sh_start),
    .tx_byte   (sh_tx),
    .half_div  (s_q.half),
    .miso_sync (s_q.miso_sync[1]),
    .sclk      (sh_sclk),
    .mosi      (sh_mosi),
    .done      (sh_done),
    .rx_byte   (sh_rx)
  );

  sfbl_skid_buf u_buf (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .in_valid  (push_valid),
    .in_data   (push_data),
    .in_ready  (push_ready),
    .out_valid (cfg_valid),
    .out_data  (cfg_data),
    .out_ready (cfg_ready)
  );

  assign isl_rd                  = s_q.isl_rd;
  assign isl_addr                = s_q.addr;
  assign flash_sclk_o            = s_q.sclk_o;
  assign flash_sclk_oe           = s_q.sclk_oe;
  assign flash_select_n_o        = s_q.sel_o;
  assign flash_select_n_oe       = s_q.sel_oe;
  assign flash_command_out_o     = s_q.mosi_o;
  assign flash_command_out_oe    = s_q.mosi_oe;
  assign user_miso               = s_q.user_miso;
  assign tap_pt_miso             = s_q.tap_miso;
  assign load_busy               = s_q.busy;
  assign load_done               = s_q.done;
  assign boot_failed             = s_q.failed;
  assign load_clock_rate_setting = s_q.rate;
endmodule : sfbl_loader
`default_nettype wire

// ### sfbl_pkg.sv
// constants shared by the boot loader modules
package sfbl_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CORE_CLK_KHZ  = 200000;
  localparam int unsigned SLOW_CLK_KHZ  = 2080;
  // half period of the default serial clock, rounded down so the rate never drops below nominal
  localparam int unsigned SLOW_HALF_INT = CORE_CLK_KHZ / (2 * SLOW_CLK_KHZ);
  localparam logic [7:0]  SLOW_HALF     = SLOW_HALF_INT[7:0];
  localparam logic [7:0]  MIN_HALF      = 8'h04;
  localparam logic [7:0]  SAMPLE_CNT    = 8'h02;
  localparam logic [2:0]  RATE_MAX      = 3'h3;
  // ****************************************
  // flash protocol
  // ****************************************
  localparam logic [7:0]  READ_OPCODE   = 8'h03;
  localparam logic [23:0] IMAGE_ADDR    = 24'h000000;
  localparam logic [1:0]  CMD_BYTES_M1  = 2'h3;
  localparam logic [15:0] PREAMBLE      = 16'ha5c3;
  localparam logic [7:0]  HUNT_MAX      = 8'hff;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  // ****************************************
  // loader states
  // ****************************************
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_SELF = 9'h002,
    ST_CMD  = 9'h004,
    ST_HUNT = 9'h008,
    ST_RATE = 9'h010,
    ST_DATA = 9'h020,
    ST_DONE = 9'h040,
    ST_FAIL = 9'h080,
    ST_WAIT = 9'h100
  } sfbl_state_t;
endpackage : sfbl_pkg

// ### sfbl_skid_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sfbl_skid_buf (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  output logic            out_valid,
  output logic [7:0]      out_data,
  input  wire logic       out_ready
);
  typedef struct packed {
    logic       v0;
    logic       v1;
    logic [7:0] d0;
    logic [7:0] d1;
  } sfbl_buf_t;

  sfbl_buf_t s_q;
  sfbl_buf_t s_d;

  always_comb begin
    s_d = s_q;
    if (s_q.v0 && out_ready) begin
      s_d.v0 = s_q.v1;
      s_d.d0 = s_q.d1;
      s_d.v1 = 1'b0;
    end
    if (in_valid && !s_q.v1) begin
      if (!s_d.v0) begin
        s_d.v0 = 1'b1;
        s_d.d0 = in_data;
      end else begin
        s_d.v1 = 1'b1;
        s_d.d1 = in_data;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign in_ready  = !s_q.v1;
  assign out_valid = s_q.v0;
  assign out_data  = s_q.d0;
endmodule : sfbl_skid_buf
`default_nettype wire

// ### sfbl_spi_shift.sv
// one-byte mode 0 shifter with its own serial clock divider
`timescale 1ns/1ps
`default_nettype none
module sfbl_spi_shift (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic [7:0] half_div,
  input  wire logic       miso_sync,
  output logic            sclk,
  output logic            mosi,
  output logic            done,
  output logic [7:0]      rx_byte
);
  typedef struct packed {
    logic       active;
    logic       sclk;
    logic       done;
    logic [7:0] cnt;
    logic [2:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
  } sfbl_shift_t;

  sfbl_shift_t s_q;
  sfbl_shift_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (!s_q.active) begin
      if (start) begin
        s_d.active = 1'b1;
        s_d.cnt    = '0;
        s_d.bitn   = '0;
        s_d.tx     = tx_byte;
      end
    end else begin
      // miso passed two sync stages, so sample a few cycles after the rising edge
      if (s_q.sclk && s_q.cnt == sfbl_pkg::SAMPLE_CNT) begin
        s_d.rx = {s_q.rx[6:0], miso_sync};
      end
      if (s_q.cnt == half_div - 8'h01) begin
        s_d.cnt  = '0;
        s_d.sclk = !s_q.sclk;
        if (s_q.sclk) begin
          // falling edge: next bit out, msb first
          if (s_q.bitn == sfbl_pkg::LAST_BIT) begin
            s_d.active = 1'b0;
            s_d.done   = 1'b1;
          end else begin
            s_d.bitn = s_q.bitn + 3'h1;
            s_d.tx   = {s_q.tx[6:0], 1'b0};
          end
        end
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign sclk    = s_q.sclk;
  assign mosi    = s_q.tx[7];
  assign done    = s_q.done;
  assign rx_byte = s_q.rx;
endmodule : sfbl_spi_shift
`default_nettype wire

// ### sfbl_properties.sv
// port-level assertion checker for the boot loader
`timescale 1ns/1ps
`default_nettype none
module sfbl_properties (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       reload_cmd,
  input wire logic       reprogram_request_n,
  input wire logic       hw_default_state,
  input wire logic       image_fits_internal,
  input wire logic       tap_pt_en,
  input wire logic       user_spi_en,
  input wire logic       flash_sclk_o,
  input wire logic       flash_sclk_oe,
  input wire logic       flash_select_n_o,
  input wire logic       flash_select_n_oe,
  input wire logic       flash_command_out_o,
  input wire logic       flash_command_out_oe,
  input wire logic [7:0] cfg_data,
  input wire logic       cfg_valid,
  input wire logic       cfg_ready,
  input wire logic       load_busy,
  input wire logic       load_done,
  input wire logic       boot_failed,
  input wire logic [7:0] load_clock_rate_setting
);
  // ********************
  // helpers
  // ********************
  logic [7:0] hi_q;
  function automatic logic [7:0] sfbl_half(input logic [7:0] r);
    return (r[2:0] > sfbl_pkg::RATE_MAX) ? (sfbl_pkg::SLOW_HALF >> 3) : (sfbl_pkg::SLOW_HALF >> r[2:0]);
  endfunction : sfbl_half
  // length of the current high phase of the serial clock pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) hi_q <= 8'h00;
    else hi_q <= flash_sclk_o ? hi_q + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ********************
  // assertions
  // ********************
  AST_START_PINS:
    assert property ($rose(load_busy) && !image_fits_internal |-> !flash_select_n_o && flash_select_n_oe
      && flash_sclk_oe && flash_command_out_oe) else $error("flash pins not taken at load start");
  AST_HWDEF_REFUSE:
    assert property (hw_default_state && !image_fits_internal && reload_cmd && !load_busy
      |-> ##3 boot_failed && !load_busy && !flash_select_n_oe) else $error("flash boot not refused");
  AST_MOSI_ON_LOW:
    assert property (load_busy && !flash_select_n_o && $changed(flash_command_out_o) |-> !flash_sclk_o)
      else $error("serial output changed while clock high");
  AST_HALF_PERIOD:
    assert property (load_busy && $fell(flash_sclk_o) |-> hi_q == sfbl_half(load_clock_rate_setting)
      || hi_q == sfbl_half($past(load_clock_rate_setting, 60))) else $error("serial clock half period wrong");
  AST_END_RELEASE:
    assert property ($fell(load_busy) |-> flash_select_n_o && !flash_select_n_oe && !flash_sclk_oe
      && !flash_command_out_oe) else $error("pins not released at load end");
  AST_IDLE_FLOAT:
    assert property ((!load_busy && !tap_pt_en && !user_spi_en)[*4] |-> !flash_select_n_oe && !flash_sclk_oe
      && !flash_command_out_oe) else $error("pins driven while idle");
  AST_RELOAD_START:
    assert property (reprogram_request_n[*3] ##0 (reload_cmd && !load_busy && !hw_default_state)
      |-> ##[1:3] load_busy) else $error("reload did not start a load");
  AST_SEL_HELD:
    assert property (load_busy && !flash_select_n_o |=> (load_busy && !flash_select_n_o)
      || (!load_busy && flash_select_n_o)) else $error("select released in mid read");
  AST_STREAM_HOLD:
    assert property (cfg_valid && !cfg_ready |=> cfg_valid && $stable(cfg_data))
      else $error("stream byte dropped while stalled");
  COV_DONE: cover property ($rose(load_done));
  COV_FAIL: cover property ($rose(boot_failed));
  COV_FAST: cover property ($fell(load_busy) && load_clock_rate_setting != 8'h00);
  COV_STALL: cover property (cfg_valid && !cfg_ready && load_busy);
endmodule : sfbl_properties
`default_nettype wire

// ### sfbl_flash_model.sv
// behavioural serial flash answering the slow read command
`timescale 1ns/1ps
`default_nettype none
module sfbl_flash_model (
  input  wire logic sclk,
  input  wire logic sel_n,
  input  wire logic mosi,
  output logic      miso
);
  logic [7:0]  mem [0:511];
  logic [31:0] cmd_q;
  logic [5:0]  nbit_q;
  logic [23:0] addr_q;
  logic [2:0]  bpos_q;
  initial miso = 1'b0;
  always @(negedge sel_n) begin
    nbit_q = 6'h00;
    bpos_q = 3'h7;
  end
  // released line has no pull: show the inverse of the last bit
  always @(posedge sel_n) miso = ~miso;
  always @(posedge sclk) begin
    if (!sel_n && nbit_q < 6'h20) begin
      cmd_q = {cmd_q[30:0], mosi};
      nbit_q = nbit_q + 6'h01;
      if (nbit_q == 6'h20) addr_q = cmd_q[23:0];
    end
  end
  always @(negedge sclk) begin
    if (!sel_n && nbit_q == 6'h20) begin
      miso = mem[addr_q[8:0]][bpos_q];
      if (bpos_q == 3'h0) addr_q = addr_q + 24'h000001;
      bpos_q = bpos_q - 3'h1;
    end
  end
endmodule : sfbl_flash_model
`default_nettype wire

// ### sfbl_tb.sv
// self-checking testbench for the boot loader
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int NB = 8;
  logic core_clk, rst_b, clk_en, reload_cmd, reprogram_request_n, hw_default_state, image_fits_internal;
  logic user_spi_en, user_sclk, user_mosi, user_select_n, tap_pt_en, tap_pt_sclk, tap_pt_mosi, tap_pt_select_n;
  logic cfg_ready, hold_rdy, isl_rd, flash_data_in, flash_sclk_o, flash_sclk_oe, flash_select_n_o;
  logic flash_select_n_oe, flash_command_out_o, flash_command_out_oe, user_miso, tap_pt_miso;
  logic cfg_valid, load_busy, load_done, boot_failed;
  logic [23:0] image_byte_count, isl_addr;
  logic [7:0]  isl_data, cfg_data, load_clock_rate_setting;
  logic [7:0]  exp_q[$], got_q[$];
  logic [31:0] seed = 32'hfb7c;
  int failures = 0, tests_run = 0, cyc = 0;
  // ********************
  // pins, far side and stream sink
  // ********************
  wire logic sclk_w = flash_sclk_oe ? flash_sclk_o : 1'b1;
  wire logic sel_w  = flash_select_n_oe ? flash_select_n_o : 1'b1;
  wire logic mosi_w = flash_command_out_oe ? flash_command_out_o : core_clk;
  sfbl_loader sfbl_loader_i (.core_clk, .rst_b, .clk_en, .reload_cmd, .reprogram_request_n, .hw_default_state,
    .image_fits_internal, .image_byte_count, .isl_rd, .isl_addr, .isl_data, .flash_data_in, .flash_sclk_o,
    .flash_sclk_oe, .flash_select_n_o, .flash_select_n_oe, .flash_command_out_o, .flash_command_out_oe,
    .user_spi_en, .user_sclk, .user_mosi, .user_select_n, .user_miso, .tap_pt_en, .tap_pt_sclk, .tap_pt_mosi,
    .tap_pt_select_n, .tap_pt_miso, .cfg_data, .cfg_valid, .cfg_ready, .load_busy, .load_done, .boot_failed,
    .load_clock_rate_setting);
  sfbl_flash_model mdl (.sclk(sclk_w), .sel_n(sel_w), .mosi(mosi_w), .miso(flash_data_in));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  always @(posedge core_clk) if (isl_rd) isl_data <= isl_addr[7:0] ^ 8'h5a;
  always @(negedge core_clk) cfg_ready <= !hold_rdy && (rnd() % 3) != 0;
  always @(posedge core_clk) if (cfg_valid && cfg_ready) got_q.push_back(cfg_data);
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      failures++;
      $display("MISMATCH %0t run too long", $time);
      wrap_up();
    end
  end
  // ********************
  // tasks
  // ********************
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wait_idle();
    for (int n = 0; n < 60000 && load_busy !== 1'b0; n++) @(negedge core_clk);
    repeat (40) @(negedge core_clk);
  endtask : wait_idle
  task automatic cmp_stream();
    check(got_q.size(), NB, "byte count");
    for (int n = 0; n < NB; n++) check(got_q[n], exp_q[n], "stream byte");
  endtask : cmp_stream
  task automatic boot_run(input logic [7:0] rate, input int trig);
    logic [31:0] r;
    exp_q.delete();
    got_q.delete();
    hold_rdy = (trig == 0);
    for (int n = 0; n < 6 + NB; n++) begin
      r = rnd();
      mdl.mem[n] = (n < 3) ? {1'b0, r[6:0]} : r[7:0];
    end
    mdl.mem[3] = sfbl_pkg::PREAMBLE[15:8];
    mdl.mem[4] = sfbl_pkg::PREAMBLE[7:0];
    mdl.mem[5] = rate;
    for (int n = 0; n < NB; n++) exp_q.push_back(mdl.mem[6 + n]);
    case (trig)
      0: rst_b = 1'b1;
      1: reload_cmd = 1'b1;
      default: reprogram_request_n = 1'b0;
    endcase
    @(negedge core_clk);
    reload_cmd = 1'b0;
    if (trig == 2) begin
      repeat (20) @(negedge core_clk);
      check(load_busy, 0, "started while pin held");
      reprogram_request_n = 1'b1;
    end
    for (int n = 0; n < 20 && load_busy !== 1'b1; n++) @(negedge core_clk);
    check(load_busy, 1, "load start");
    if (trig == 0) begin
      repeat (12000) @(negedge core_clk);
      check({load_busy, cfg_valid, got_q.size() == 0}, 3'b111, "stall with buffer full");
      hold_rdy = 1'b0;
    end
    wait_idle();
    check({load_done, boot_failed}, 2'b10, "load done");
    check(mdl.cmd_q, {sfbl_pkg::READ_OPCODE, sfbl_pkg::IMAGE_ADDR}, "read command");
    check(load_clock_rate_setting, rate, "rate setting");
    cmp_stream();
    $display("test flash boot rate %h ended", rate);
  endtask : boot_run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // ********************
  // main sequence
  // ********************
  initial begin
    logic [31:0] r;
    {rst_b, reload_cmd, hw_default_state, image_fits_internal, user_spi_en, user_sclk, user_mosi} = '0;
    {tap_pt_en, tap_pt_sclk, tap_pt_mosi, hold_rdy, cfg_ready} = '0;
    {clk_en, reprogram_request_n, user_select_n, tap_pt_select_n} = '1;
    image_byte_count = 24'h000008;
    isl_data = 8'h00;
    repeat (5) @(negedge core_clk);
    boot_run(8'h00, 0);
    boot_run(8'h01, 1);
    boot_run(8'h02, 2);
    boot_run(8'hff, 1);
    exp_q.delete();
    got_q.delete();
    for (int n = 0; n < NB; n++) exp_q.push_back(n[7:0] ^ 8'h5a);
    image_fits_internal = 1'b1;
    reload_cmd = 1'b1;
    @(negedge core_clk);
    reload_cmd = 1'b0;
    repeat (6) @(negedge core_clk);
    check({load_busy, flash_select_n_oe}, 2'b10, "self load keeps pins off");
    wait_idle();
    cmp_stream();
    $display("test self load ended");
    image_fits_internal = 1'b0;
    hw_default_state = 1'b1;
    reload_cmd = 1'b1;
    @(negedge core_clk);
    reload_cmd = 1'b0;
    repeat (6) @(negedge core_clk);
    check({boot_failed, load_busy, flash_select_n_oe}, 3'b100, "default state refusal");
    hw_default_state = 1'b0;
    $display("test default state ended");
    tap_pt_en = 1'b1;
    tap_pt_select_n = 1'b0;
    for (int n = 0; n < 8; n++) begin
      r = rnd();
      tap_pt_mosi = r[0];
      #32 tap_pt_sclk = 1'b1;
      #20 check({flash_sclk_o, flash_command_out_o, flash_select_n_o, flash_sclk_oe}, {1'b1, tap_pt_mosi, 2'b01}, "pass-through");
      #12 tap_pt_sclk = 1'b0;
    end
    #32 tap_pt_select_n = 1'b1;
    @(negedge core_clk);
    {tap_pt_en, user_spi_en, user_select_n, user_sclk, user_mosi} = 5'b01011;
    repeat (4) @(negedge core_clk);
    check({flash_select_n_o, flash_sclk_o, flash_command_out_o, flash_select_n_oe}, 4'b0111, "user master");
    {user_spi_en, user_select_n} = 2'b01;
    repeat (5) @(negedge core_clk);
    check({flash_select_n_oe, flash_sclk_oe, flash_command_out_oe}, 3'b000, "pins float idle");
    $display("test pin sharing ended");
    wrap_up();
  end
endmodule : tb
bind sfbl_loader sfbl_properties sfbl_properties_i (.core_clk, .rst_b, .reload_cmd, .reprogram_request_n,
  .hw_default_state, .image_fits_internal, .tap_pt_en, .user_spi_en, .flash_sclk_o, .flash_sclk_oe,
  .flash_select_n_o, .flash_select_n_oe, .flash_command_out_o, .flash_command_out_oe, .cfg_data, .cfg_valid,
  .cfg_ready, .load_busy, .load_done, .boot_failed, .load_clock_rate_setting);
`default_nettype wire
